// ### hw/hrl_loader.sv
// Hex record loader: ASCII record stream in, checked memory writes out
// Summary of operation
// - Each byte arrives as two hex characters, high nibble first.
// - Record fields: type, length, address, optional payload, checksum.
// - Length counts the byte pairs after it, including checksum.
// - Address is two, three or four bytes depending on type.
// - Checksum is the low byte of the inverted sum of the length, address and data bytes.
// - Carriage return, line feed or null after a record is ignored.
// - Leading text before the record start is skipped.
// - Only two-byte data and end records are acted on.
// - Everything before the first data record loads nothing.
// - After first data record only data records until the end record.
// - Header records carry free text and load nothing.
// - Data payload is written from the record address upward.
// - Types two to eight never cause a memory write.
// - End record has no payload; its address is the start address.
// - One end record per block; several headers are accepted.
// - Each record is checked for byte count and checksum.
`timescale 1ns/1ps
module hrl_loader
  import hrl_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH,
  parameter int BDEPTH = BUF_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ch_valid,
  output logic             ch_ready,
  input  wire logic [7:0]  ch_data,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output hrl_wr_type       wr_out,
  input  wire logic        err_clr,
  output hrl_err_type      err_flags,
  output logic             loading,
  output logic             done,
  output logic [15:0]      exec_addr
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  hrl_state_type state_r;
  hrl_state_type state_nxt;
  logic          hi_r;
  logic [3:0]    nib_hi_r;
  logic [3:0]    type_r;
  logic [7:0]    remain_r;
  logic [7:0]    sum_r;
  logic [15:0]   addr_r;
  logic [1:0]    aidx_r;
  logic [7:0]    cnt_r;
  logic [7:0]    eidx_r;
  logic          loading_r;
  logic          done_r;
  logic [15:0]   exec_r;
  hrl_err_type   err_r;
  hrl_err_type   err_set;
  logic [7:0]    buf_mem [BDEPTH];

  // ------------------------------------------------------------------
  // Character decode
  // ------------------------------------------------------------------
  wire        take    = ch_valid && ch_ready;
  wire        is_dig  = (ch_data >= CH_ZERO) && (ch_data <= CH_NINE);
  wire        is_up   = (ch_data >= CH_UA) && (ch_data <= CH_UF);
  wire        is_low  = (ch_data >= CH_LA) && (ch_data <= CH_LF);
  wire        is_hex  = is_dig || is_up || is_low;
  wire        is_sep  = (ch_data == CH_CR) || (ch_data == CH_NL) ||
                        (ch_data == CH_NUL);
  wire [3:0]  nib     = is_dig ? ch_data[3:0] : ch_data[3:0] + NIB_ALPHA;
  wire        in_byte = (state_r == ST_LEN) || (state_r == ST_ADDR) ||
                        (state_r == ST_DATA) || (state_r == ST_SUM);
  wire        bad_ch  = take && in_byte && !is_hex;
  wire        byte_done = take && in_byte && is_hex && hi_r;
  wire [7:0]  byte_val  = {nib_hi_r, nib};
  wire [7:0]  rem_dec   = remain_r - ONE;

  wire [1:0]  alast = (type_r == T_A3A || type_r == T_A3B) ? ALAST3 :
                      (type_r == T_A4A || type_r == T_A4B) ? ALAST4 :
                      ALAST2;
  wire        addr_end = (aidx_r == alast);

  // ------------------------------------------------------------------
  // Record verdict
  // ------------------------------------------------------------------
  wire        at_sum   = (state_r == ST_SUM) && byte_done;
  wire        sum_ok   = (byte_val == ~sum_r);
  wire        is_data  = (type_r == T_DATA);
  wire        is_end   = (type_r == T_END);
  // only data or end once loading
  wire        seq_bad  = loading_r && !is_data && !is_end;
  wire        end_bad  = is_end && (cnt_r != 8'h00);
  wire        rec_ok   = at_sum && sum_ok && !seq_bad && !end_bad;
  wire        load_go  = rec_ok && is_data && (cnt_r != 8'h00);

  // ------------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------------
  wire        push     = (state_r == ST_EMIT);
  logic       fifo_rdy;
  wire        adv      = push && fifo_rdy;
  wire        emit_end = adv && (eidx_r == cnt_r - ONE);
  hrl_wr_type push_word;

  assign push_word.addr = addr_r + {8'h00, eidx_r};
  assign push_word.data = buf_mem[eidx_r];

  // Input stalls while a checked record drains into the buffer
  assign ch_ready  = (state_r != ST_EMIT);
  assign err_flags = err_r;
  assign loading   = loading_r;
  assign done      = done_r;
  assign exec_addr = exec_r;

  hrl_fifo #(
    .WIDTH ($bits(hrl_wr_type)),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (push_word),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_out)
  );

  // ------------------------------------------------------------------
  // Record parser
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    err_set   = '0;
    unique case (state_r)
      ST_HUNT: begin
        if (take && ch_data == CH_S) begin
          state_nxt = ST_TYPE;
        end
      end
      ST_TYPE: begin
        if (take) begin
          state_nxt = is_dig ? ST_LEN : ST_HUNT;
          err_set.hex = !is_dig;
        end
      end
      ST_EMIT: begin
        if (emit_end) begin
          state_nxt = ST_HUNT;
        end
      end
      default: begin
        if (bad_ch) begin
          err_set.len = is_sep;
          err_set.hex = !is_sep;
          state_nxt   = ST_HUNT;
        end else if (byte_done) begin
          if (state_r == ST_LEN) begin
            err_set.len = (byte_val < MIN_LEN);
            state_nxt   = (byte_val < MIN_LEN) ? ST_HUNT : ST_ADDR;
          end else if (state_r == ST_ADDR && addr_end) begin
            state_nxt = (rem_dec == ONE) ? ST_SUM : ST_DATA;
          end else if (state_r == ST_DATA && rem_dec == ONE) begin
            state_nxt = ST_SUM;
          end else if (state_r == ST_SUM) begin
            err_set.sum = !sum_ok;
            err_set.seq = sum_ok && seq_bad;
            err_set.len = sum_ok && end_bad;
            state_nxt   = load_go ? ST_EMIT : ST_HUNT;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_HUNT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Field assembly
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_r     <= 1'b0;
      nib_hi_r <= 4'h0;
      type_r   <= 4'h0;
    end else if (state_r == ST_TYPE && take) begin
      hi_r   <= 1'b0;
      type_r <= ch_data[3:0];
    end else if (take && in_byte && is_hex) begin
      hi_r     <= !hi_r;
      nib_hi_r <= nib;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain_r <= 8'h00;
      sum_r    <= 8'h00;
    end else if (byte_done && state_r == ST_LEN) begin
      remain_r <= byte_val;
      sum_r    <= byte_val;
    end else if (byte_done && state_r != ST_SUM) begin
      remain_r <= rem_dec;
      sum_r    <= sum_r + byte_val;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= 16'h0000;
      aidx_r <= 2'h0;
    end else if (state_r == ST_TYPE && take) begin
      addr_r <= 16'h0000;
      aidx_r <= 2'h0;
    end else if (byte_done && state_r == ST_ADDR) begin
      addr_r <= {addr_r[7:0], byte_val};
      aidx_r <= aidx_r + 2'h1;
    end
  end

  // payload held back until the checksum passes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= 8'h00;
      eidx_r <= 8'h00;
    end else begin
      if (byte_done && state_r == ST_LEN) begin
        cnt_r <= 8'h00;
      end else if (byte_done && state_r == ST_DATA) begin
        cnt_r <= cnt_r + ONE;
      end
      if (state_r != ST_EMIT) begin
        eidx_r <= 8'h00;
      end else if (adv) begin
        eidx_r <= eidx_r + ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (byte_done && state_r == ST_DATA) begin
      buf_mem[cnt_r] <= byte_val;
    end
  end

  // ------------------------------------------------------------------
  // Block sequencing and status
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loading_r <= 1'b0;
      done_r    <= 1'b0;
      exec_r    <= 16'h0000;
    end else begin
      done_r <= 1'b0;
      // first good data record opens the block
      if (rec_ok && is_data) begin
        loading_r <= 1'b1;
      end
      // single end record closes the block
      if (rec_ok && is_end && loading_r) begin
        loading_r <= 1'b0;
        done_r    <= 1'b1;
        exec_r    <= addr_r;
      end
    end
  end

  // sticky error, a new event wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_r <= '0;
    end else begin
      err_r <= (err_r & ~{4{err_clr}}) | err_set;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_push_after_good;
    push && !$past(push) |-> $past(load_go);
  endproperty
  a_push_after_good: assert property (p_push_after_good)
    else $error("write issued without a verified data record");

  property p_bad_char_flag;
    bad_ch && !is_sep |=> err_r.hex;
  endproperty
  a_bad_char_flag: assert property (p_bad_char_flag)
    else $error("non-hex character did not raise the error flag");

  property p_addr_step;
    adv && !emit_end |=> push_word.addr == $past(push_word.addr) + 16'h1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("write address did not step by one");

  property p_bad_sum;
    at_sum && !sum_ok |=> state_r == ST_HUNT && err_r.sum;
  endproperty
  a_bad_sum: assert property (p_bad_sum)
    else $error("checksum mismatch not rejected");

  property p_done_cause;
    done_r |-> $past(is_end) && $past(at_sum) && !loading_r;
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done without an end record");

  property p_no_load_other;
    at_sum && !is_data |=> state_r != ST_EMIT;
  endproperty
  a_no_load_other: assert property (p_no_load_other)
    else $error("non-data record started a memory load");

  property p_short_len;
    byte_done && state_r == ST_LEN && byte_val < MIN_LEN
      |=> err_r.len ##1 err_r.len || $past(err_clr);
  endproperty
  a_short_len: assert property (p_short_len)
    else $error("short length field not flagged");

  property p_err_hold;
    err_r.seq && !err_clr |=> err_r.seq ##1 (err_r.seq || $past(err_clr));
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("sequence error flag dropped without a clear");

  property p_emit_stall;
    state_r == ST_EMIT && !fifo_rdy
      |=> state_r == ST_EMIT && $stable(eidx_r) && !ch_ready;
  endproperty
  a_emit_stall: assert property (p_emit_stall)
    else $error("drain moved on while the buffer was full");

endmodule : hrl_loader

// ### hw/hrl_pkg.sv
// Shared constants and types of the hex record loader
package hrl_pkg;

  // ------------------------------------------------------------------
  // Character codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CH_S    = 8'h53;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_UA   = 8'h41;
  localparam logic [7:0] CH_UF   = 8'h46;
  localparam logic [7:0] CH_LA   = 8'h61;
  localparam logic [7:0] CH_LF   = 8'h66;
  localparam logic [7:0] CH_CR   = 8'h0d;
  localparam logic [7:0] CH_NL   = 8'h0a;
  localparam logic [7:0] CH_NUL  = 8'h00;
  localparam logic [3:0] NIB_ALPHA = 4'h9;

  // ------------------------------------------------------------------
  // Record types and field sizes
  // ------------------------------------------------------------------
  localparam logic [3:0] T_HDR  = 4'h0;
  localparam logic [3:0] T_DATA = 4'h1;
  localparam logic [3:0] T_A3A  = 4'h2;
  localparam logic [3:0] T_A4A  = 4'h3;
  localparam logic [3:0] T_A4B  = 4'h7;
  localparam logic [3:0] T_A3B  = 4'h8;
  localparam logic [3:0] T_END  = 4'h9;
  // Index of the last address byte for 2, 3 and 4 byte addresses
  localparam logic [1:0] ALAST2 = 2'h1;
  localparam logic [1:0] ALAST3 = 2'h2;
  localparam logic [1:0] ALAST4 = 2'h3;
  // Two address bytes plus the checksum byte
  localparam logic [7:0] MIN_LEN = 8'h03;
  localparam logic [7:0] ONE     = 8'h01;
  localparam int FIFO_DEPTH = 16;
  localparam int BUF_DEPTH  = 256;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HUNT = 3'h0,
    ST_TYPE = 3'h1,
    ST_LEN  = 3'h3,
    ST_ADDR = 3'h2,
    ST_DATA = 3'h6,
    ST_SUM  = 3'h7,
    ST_EMIT = 3'h5
  } hrl_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } hrl_wr_type;

  typedef struct packed {
    logic hex;
    logic len;
    logic sum;
    logic seq;
  } hrl_err_type;

endpackage : hrl_pkg

// ### hw/hrl_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module hrl_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  wire              full  = (wr_r[AW] != rd_r[AW]) &&
                            (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire              empty = (wr_r == rd_r);
  wire              push  = in_valid && !full;
  wire              pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + (AW+1)'(1);
      end
      if (pop) begin
        rd_r <= rd_r + (AW+1)'(1);
      end
    end
  end

endmodule : hrl_fifo

// ### verif/hrl_host.sv
// Host model that sends hex record text one character at a time
`timescale 1ns/1ps
module hrl_host (
  input  wire logic       clk,
  input  wire logic       ch_ready,
  output logic            ch_valid,
  output logic [7:0]      ch_data
);
  initial begin
    ch_valid = 1'b0;
    ch_data  = 8'h00;
  end

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n > 4'h9) ? 8'h37 + 8'(n) : 8'h30 + 8'(n);
  endfunction : hex_ch

  // Idle line is inverted at each release, so two releases in a row show the last character again
  task automatic release_line();
    @(negedge clk);
    ch_valid = 1'b0;
    ch_data  = ~ch_data;
  endtask : release_line

  // Character held until the rising edge that sees ready high
  task automatic send_ch(input logic [7:0] c, input int gap);
    @(negedge clk);
    ch_valid = 1'b1;
    ch_data  = c;
    while (ch_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    repeat (gap) release_line();
  endtask : send_ch

  task automatic send_byte(input logic [7:0] b, input int gap);
    send_ch(hex_ch(b[7:4]), gap);
    send_ch(hex_ch(b[3:0]), gap);
  endtask : send_byte

  task automatic send_str(input string s, input int gap);
    for (int i = 0; i < s.len(); i++) send_ch(8'(s[i]), gap);
    release_line();
  endtask : send_str

  // fields in order, payload up to 254 bytes less the address length
  task automatic send_rec(input logic [7:0] t, input int alen,
                          input logic [31:0] addr, input logic [7:0] pl[$],
                          input int gap);
    logic [7:0] len;
    logic [7:0] sum;
    len = 8'(alen + pl.size() + 1);
    sum = len;
    send_ch(8'h53, gap);
    send_ch(t, gap);
    send_byte(len, gap);
    for (int i = alen - 1; i >= 0; i--) begin
      sum = sum + addr[8*i +: 8];
      send_byte(addr[8*i +: 8], gap);
    end
    foreach (pl[i]) begin
      sum = sum + pl[i];
      send_byte(pl[i], gap);
    end
    send_byte(~sum, gap);
    release_line();
  endtask : send_rec
endmodule : hrl_host

// ### verif/test_hrl_loader.sv
// Self-checking testbench of the hex record loader
`timescale 1ns/1ps
module test_hrl_loader
  import hrl_pkg::*;
;
  logic        clk;
  logic        rstn;
  logic        ch_valid;
  logic        ch_ready;
  logic [7:0]  ch_data;
  logic        wr_valid;
  logic        wr_ready;
  hrl_wr_type  wr_out;
  logic        err_clr;
  hrl_err_type err_flags;
  logic        loading;
  logic        done;
  logic [15:0] exec_addr;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          done_cnt = 0;
  hrl_wr_type  got[$];
  hrl_wr_type  exp_q[$];
  logic [7:0]  pl[$];

  hrl_loader hrl_loader_inst (
    .clk(clk), .rstn(rstn), .ch_valid(ch_valid), .ch_ready(ch_ready),
    .ch_data(ch_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_out(wr_out), .err_clr(err_clr), .err_flags(err_flags),
    .loading(loading), .done(done), .exec_addr(exec_addr)
  );
  hrl_host hrl_host_inst (
    .clk(clk), .ch_ready(ch_ready), .ch_valid(ch_valid), .ch_data(ch_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Memory side monitor and hang guard
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back(wr_out);
    if (done === 1'b1) done_cnt++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait until input is open and the write side is empty
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((ch_ready !== 1'b1 || wr_valid !== 1'b0) && n < 300);
    @(negedge clk);
  endtask : settle

  task automatic check_writes();
    check(32'(got.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got.size()) check(32'(got[i]), 32'(exp_q[i]));
    got.delete();
    exp_q.delete();
  endtask : check_writes

  task automatic clear_err();
    @(negedge clk);
    err_clr = 1'b1;
    @(negedge clk);
    err_clr = 1'b0;
  endtask : clear_err

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_basic();
    hrl_host_inst.send_str("12 ", 0);
    pl = '{8'h48, 8'h44, 8'h52};
    hrl_host_inst.send_rec(8'h30, 2, 32'h0, pl, 0);
    hrl_host_inst.send_rec(8'h30, 2, 32'h0, pl, 0);
    pl.delete();
    hrl_host_inst.send_rec(8'h39, 2, 32'h5555, pl, 0);
    settle();
    check(32'(done_cnt), 32'h0);
    check(32'(loading), 32'h0);
    check(32'(got.size()), 32'h0);
    hrl_host_inst.send_str("S1050010abcd72\015\n", 0);
    hrl_host_inst.send_ch(8'h00, 0);
    hrl_host_inst.release_line();
    settle();
    exp_q.push_back({16'h0010, 8'hab});
    exp_q.push_back({16'h0011, 8'hcd});
    check_writes();
    check(32'(loading), 32'h1);
    check(32'(err_flags), 32'h0);
    hrl_host_inst.send_rec(8'h39, 2, 32'h1234, pl, 0);
    settle();
    check(32'(done_cnt), 32'h1);
    check(32'(exec_addr), 32'h1234);
    check(32'(loading), 32'h0);
    $display("t_basic finished");
  endtask : t_basic

  task automatic t_types();
    logic [7:0] tc[6] = '{8'h30, 8'h32, 8'h33, 8'h35, 8'h37, 8'h38};
    int         al[6] = '{2, 3, 4, 2, 4, 3};
    pl.delete();
    hrl_host_inst.send_rec(8'h31, 2, 32'h0200, pl, 0);
    settle();
    check(32'(loading), 32'h1);
    pl.push_back(8'h5a);
    for (int i = 0; i < 6; i++) begin
      hrl_host_inst.send_rec(tc[i], al[i], 32'h0a0b0c0d, pl, 0);
      settle();
      check(32'(err_flags), 32'h1);
      check(32'(got.size()), 32'h0);
      clear_err();
    end
    check(32'(err_flags), 32'h0);
    $display("t_types finished");
  endtask : t_types

  task automatic t_bad();
    string      s[5] = '{"S1050010abcd73\015", "S1050010xbcd72\015",
                         "S10200FD\015", "S1050010ab\015",
                         "SZ050010abcd72\015"};
    logic [3:0] ef[5] = '{4'h2, 4'h8, 4'h4, 4'h4, 4'h8};
    for (int i = 0; i < 5; i++) begin
      hrl_host_inst.send_str(s[i], 0);
      settle();
      check(32'(err_flags), 32'(ef[i]));
      check(32'(got.size()), 32'h0);
      clear_err();
      check(32'(err_flags), 32'h0);
    end
    $display("t_bad finished");
  endtask : t_bad

  task automatic t_fifo();
    pl.delete();
    for (int i = 0; i < 20; i++) begin
      pl.push_back(8'(8'h11 * i + 3));
      exp_q.push_back({16'(16'h0100 + i), pl[i]});
    end
    @(negedge clk);
    wr_ready = 1'b0;
    fork
      hrl_host_inst.send_rec(8'h31, 2, 32'h0100, pl, 1);
    join_none
    repeat (150) @(negedge clk);
    // Twenty bytes overflow the sixteen entries, so input must stall
    check(32'(ch_ready), 32'h0);
    check(32'(wr_valid), 32'h1);
    check(32'(got.size()), 32'h0);
    repeat (40) begin
      @(negedge clk);
      wr_ready = ~wr_ready;
    end
    @(negedge clk);
    wr_ready = 1'b1;
    wait fork;
    settle();
    check_writes();
    pl.delete();
    hrl_host_inst.send_rec(8'h39, 2, 32'h0100, pl, 0);
    settle();
    check(32'(done_cnt), 32'h2);
    check(32'(exec_addr), 32'h0100);
    $display("t_fifo finished");
  endtask : t_fifo

  initial begin
    rstn     = 1'b0;
    wr_ready = 1'b1;
    err_clr  = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    check(32'(err_flags), 32'h0);
    t_basic();
    t_types();
    t_bad();
    t_fifo();
    report_and_stop();
  end
endmodule : test_hrl_loader
